// >>> sop_array_top.sv
// sum-of-products logic array with macro-cell outputs, preload, programming and security
// assumes all pins are synchronous to clk_i; logic_clk_i is the shared register clock as a level
// Operation
// - outputs are sums of programmable AND terms through fixed OR gates.
// - blank cells connect every term to both input polarities; writing removes one.
// - combinational output: term 0 enables inverting driver, seven terms ORed, inverted.
// - registered output: eight terms ORed into flip-flop, common clock, common enable.
// - registered outputs feed back into the AND array as inputs.
// - each output independently chosen combinational or registered.
// - preload: enable high, data on pins, 100 us pulse loads registers.
// - once security cell is written, regular array readback is blocked.
// - each programming operation writes eight cells with a 100 us to 10 ms pulse; the security write sets only the one security cell.
// - term joined to both polarities of one input is constantly low.
// - regular array addressed as 256 bytes, test array as 32 bytes.
`timescale 1ns/1ps
module sop_array_top #(
  parameter int NUM_INPUTS  = sop_array_pkg::NUM_INPUTS,
  parameter int NUM_OUTPUTS = sop_array_pkg::NUM_OUTPUTS,
  parameter int PGM_CYC     = sop_array_pkg::PGM_PULSE_MIN_CYC,
  parameter int PRELOAD_CYC = sop_array_pkg::PRELOAD_MIN_CYC
) (
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          ce_i,
  input  wire sop_array_pkg::apb_req_t       apb_i,
  output logic                               pready_o,
  output logic [31:0]                        prdata_o,
  output logic                               pslverr_o,
  input  wire logic [NUM_INPUTS-1:0]         in_i,
  input  wire logic                          logic_clk_i,
  input  wire logic                          out_en_n_i,
  input  wire logic                          preload_i,
  input  wire logic [NUM_OUTPUTS-1:0]        pin_i,
  output logic [NUM_OUTPUTS-1:0]             pin_o,
  output logic [NUM_OUTPUTS-1:0]             pin_oe_n_o
);

  localparam int TPO   = sop_array_pkg::TERMS_PER_OUT;
  localparam int NSIG  = NUM_INPUTS + NUM_OUTPUTS;
  localparam int LITS  = 2 * NSIG;
  localparam int BPT   = LITS / sop_array_pkg::CELLS_PER_OP;
  localparam int NTERM = NUM_OUTPUTS * TPO;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > sop_array_pkg::MAX_OUTPUTS || LITS % 8 != 0 ||
      NTERM * BPT > sop_array_pkg::REGULAR_BYTES || NUM_INPUTS < 1) begin : g_bad_geom
    $error("array geometry does not fit the regular array");
  end
  if (PGM_CYC < 1 || PGM_CYC > sop_array_pkg::PGM_PULSE_MAX_CYC || PRELOAD_CYC < 1) begin : g_bad_time
    $error("pulse counts out of range");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]                cells_q [sop_array_pkg::REGULAR_BYTES];
  logic [7:0]                test_q  [sop_array_pkg::TEST_BYTES];
  logic                      secured_q;
  logic [8:0]                pgm_addr_q;
  logic [NUM_OUTPUTS-1:0]    macro_q;
  sop_array_pkg::pgm_state_t pgm_state_q;
  sop_array_pkg::pgm_op_t    op_q;
  logic [31:0]               pgm_cnt_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic [31:0]               prdata_q;
  logic                      lclk_q;
  logic [31:0]               pl_cnt_q;
  logic                      pl_done_q;
  logic [NUM_OUTPUTS-1:0]    reg_q;
  logic [NUM_OUTPUTS-1:0]    pin_q;
  logic [NUM_OUTPUTS-1:0]    oe_n_q;

  // ---------------------------------------------------------------
  // AND array and OR gates
  // ---------------------------------------------------------------
  logic [NSIG-1:0]        sig;
  logic [LITS-1:0]        lits;
  logic [LITS-1:0]        cut [NTERM];
  logic [NTERM-1:0]       hit;
  logic [NUM_OUTPUTS-1:0] sum_all;
  logic [NUM_OUTPUTS-1:0] sum_rest;
  logic [NUM_OUTPUTS-1:0] pt_oe;

  always_comb begin
    for (int o = 0; o < NUM_OUTPUTS; o++) begin
      sig[NUM_INPUTS+o] = macro_q[o] ? reg_q[o] : pin_i[o];
    end
    sig[NUM_INPUTS-1:0] = in_i;
    for (int k = 0; k < NSIG; k++) begin
      lits[2*k]   = sig[k];
      lits[2*k+1] = ~sig[k];
    end
  end

  always_comb begin
    for (int t = 0; t < NTERM; t++) begin
      for (int b = 0; b < BPT; b++) begin
        cut[t][b*8 +: 8] = cells_q[t*BPT+b];
      end
    end
  end

  for (genvar t = 0; t < NTERM; t++) begin : g_term
    // connection removed only by written cell
    product_term #(
      .LITS (LITS)
    ) u_term (
      .lit_i (lits),
      .cut_i (cut[t]),
      .hit_o (hit[t])
    );
  end

  always_comb begin
    for (int o = 0; o < NUM_OUTPUTS; o++) begin
      sum_all[o]  = |hit[o*TPO +: TPO];
      sum_rest[o] = |hit[o*TPO+1 +: TPO-1];
      pt_oe[o]    = hit[o*TPO];
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic        setup;
  logic        acc_done;
  logic        busy;
  logic        launch;
  logic [31:0] rd_val;

  function automatic logic reg_known(input logic [11:0] a);
    return a == sop_array_pkg::OFS_PGM_ADDR || a == sop_array_pkg::OFS_PGM_DATA ||
           a == sop_array_pkg::OFS_MACRO_CFG || a == sop_array_pkg::OFS_SECURE ||
           a == sop_array_pkg::OFS_STATUS;
  endfunction

  function automatic logic wr_refused(input logic [11:0] a, input logic bsy, input logic [8:0] pa);
    if (a == sop_array_pkg::OFS_SECURE) begin
      return bsy;
    end else if (a == sop_array_pkg::OFS_PGM_DATA) begin
      // test array holds only 32 bytes
      return bsy || (pa[sop_array_pkg::PGM_ADDR_TEST_BIT] && pa[7:0] >= 8'(sop_array_pkg::TEST_BYTES));
    end else begin
      return 1'b0;
    end
  endfunction

  assign setup    = apb_i.psel & ~apb_i.penable;
  assign acc_done = apb_i.psel & apb_i.penable & pready_q;
  assign busy     = pgm_state_q == sop_array_pkg::PGM_PULSE;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (apb_i.paddr == sop_array_pkg::OFS_PGM_ADDR) begin
      rd_val[8:0] = pgm_addr_q;
    end else if (apb_i.paddr == sop_array_pkg::OFS_PGM_DATA) begin
      if (pgm_addr_q[sop_array_pkg::PGM_ADDR_TEST_BIT]) begin
        rd_val[7:0] = test_q[pgm_addr_q[4:0]];
      end else if (!secured_q) begin
        rd_val[7:0] = cells_q[pgm_addr_q[7:0]];
      end
    end else if (apb_i.paddr == sop_array_pkg::OFS_MACRO_CFG) begin
      rd_val[NUM_OUTPUTS-1:0] = macro_q;
    end else if (apb_i.paddr == sop_array_pkg::OFS_STATUS) begin
      rd_val[sop_array_pkg::STAT_BUSY_BIT]    = busy;
      rd_val[sop_array_pkg::STAT_SECURE_BIT]  = secured_q;
      rd_val[sop_array_pkg::STAT_PRELOAD_BIT] = pl_done_q;
    end
  end

  // answer is prepared in setup so the access phase ends in one cycle whenever ce_i is high during setup
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_q  <= setup;
      pslverr_q <= setup & (~reg_known(apb_i.paddr) |
                   (apb_i.pwrite & wr_refused(apb_i.paddr, busy, pgm_addr_q)));
      prdata_q  <= (setup & ~apb_i.pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o  = prdata_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pgm_addr_q <= sop_array_pkg::PGM_ADDR_RST;
      macro_q    <= NUM_OUTPUTS'(sop_array_pkg::MACRO_CFG_RST);
    end else if (ce_i && acc_done && apb_i.pwrite && !pslverr_q) begin
      if (apb_i.paddr == sop_array_pkg::OFS_PGM_ADDR) begin
        pgm_addr_q <= apb_i.pwdata[8:0];
      end else if (apb_i.paddr == sop_array_pkg::OFS_MACRO_CFG) begin
        macro_q <= apb_i.pwdata[NUM_OUTPUTS-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // programming pulse
  // ---------------------------------------------------------------
  sop_array_pkg::pgm_op_t new_op;
  logic                   commit;

  assign launch = acc_done & apb_i.pwrite & ~pslverr_q &
                  ((apb_i.paddr == sop_array_pkg::OFS_PGM_DATA) |
                   (apb_i.paddr == sop_array_pkg::OFS_SECURE & apb_i.pwdata[0]));
  assign new_op = '{sec:  apb_i.paddr == sop_array_pkg::OFS_SECURE,
                    test: pgm_addr_q[sop_array_pkg::PGM_ADDR_TEST_BIT],
                    addr: pgm_addr_q[7:0],
                    data: apb_i.pwdata[7:0]};
  assign commit = busy & (pgm_cnt_q == 32'(PGM_CYC - 1));

  // one pulse of fixed least length per operation
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pgm_state_q <= sop_array_pkg::PGM_IDLE;
      pgm_cnt_q   <= 32'h0000_0000;
      op_q        <= '0;
    end else if (ce_i) begin
      case (pgm_state_q)
        sop_array_pkg::PGM_IDLE: begin
          if (launch) begin
            pgm_state_q <= sop_array_pkg::PGM_PULSE;
            pgm_cnt_q   <= 32'h0000_0000;
            op_q        <= new_op;
          end
        end
        sop_array_pkg::PGM_PULSE: begin
          if (commit) begin
            pgm_state_q <= sop_array_pkg::PGM_IDLE;
          end else begin
            pgm_cnt_q <= pgm_cnt_q + 32'h0000_0001;
          end
        end
        default: pgm_state_q <= sop_array_pkg::PGM_IDLE;
      endcase
    end
  end

  // outside reset cells only gain cut bits; only sys_rst_i clears them and reconnects every literal
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < sop_array_pkg::REGULAR_BYTES; i++) begin
        cells_q[i] <= 8'h00;
      end
      for (int i = 0; i < sop_array_pkg::TEST_BYTES; i++) begin
        test_q[i] <= 8'h00;
      end
      secured_q <= 1'b0;
    end else if (ce_i && commit) begin
      if (op_q.sec) begin
        secured_q <= 1'b1;
      end else if (op_q.test) begin
        test_q[op_q.addr[4:0]] <= test_q[op_q.addr[4:0]] | op_q.data;
      end else begin
        cells_q[op_q.addr] <= cells_q[op_q.addr] | op_q.data;
      end
    end
  end

  // ---------------------------------------------------------------
  // preload and output registers
  // ---------------------------------------------------------------
  logic tick;
  logic pl_active;
  logic pl_load;

  assign tick      = logic_clk_i & ~lclk_q;
  assign pl_active = preload_i & out_en_n_i;
  // load once the pulse has lasted its least length
  assign pl_load   = pl_active & ~pl_done_q & (pl_cnt_q == 32'(PRELOAD_CYC - 1));

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pl_cnt_q  <= 32'h0000_0000;
      pl_done_q <= 1'b0;
    end else if (ce_i) begin
      if (!pl_active) begin
        pl_cnt_q  <= 32'h0000_0000;
        pl_done_q <= 1'b0;
      end else if (pl_load) begin
        pl_done_q <= 1'b1;
      end else if (!pl_done_q) begin
        pl_cnt_q <= pl_cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lclk_q <= 1'b0;
      reg_q  <= '0;
    end else if (ce_i) begin
      lclk_q <= logic_clk_i;
      // preload wins over a coincident clock edge
      if (pl_load) begin
        reg_q <= pin_i;
      // preloaded value held until next edge
      end else if (tick) begin
        // capture OR result on shared clock
        reg_q <= sum_all;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_q  <= '0;
      oe_n_q <= '1;
    end else if (ce_i) begin
      for (int o = 0; o < NUM_OUTPUTS; o++) begin
        if (macro_q[o]) begin
          pin_q[o]  <= reg_q[o];
          oe_n_q[o] <= out_en_n_i;
        end else begin
          // term 0 enables, rest ORed and inverted
          pin_q[o]  <= ~sum_rest[o];
          oe_n_q[o] <= ~pt_oe[o];
        end
      end
    end
  end

  assign pin_o      = pin_q;
  assign pin_oe_n_o = oe_n_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [31:0] busy_len_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_len_q <= 32'h0000_0000;
    end else if (ce_i) begin
      busy_len_q <= busy ? busy_len_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  AST_SEC_HIDES: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    setup && !apb_i.pwrite && apb_i.paddr == sop_array_pkg::OFS_PGM_DATA &&
    !pgm_addr_q[sop_array_pkg::PGM_ADDR_TEST_BIT] && secured_q |=> prdata_o == 32'h0000_0000)
    else $error("secured array read back non-zero");
  AST_PULSE_LEN: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    $fell(busy) |-> busy_len_q == 32'(PGM_CYC))
    else $error("programming pulse length wrong");
  AST_CUT_ONLY: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    commit && !op_q.sec && !op_q.test |=>
    (cells_q[$past(op_q.addr)] & $past(op_q.data)) == $past(op_q.data))
    else $error("programmed cells not cut");
  AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    setup && !reg_known(apb_i.paddr) |=> pready_o && pslverr_o)
    else $error("unmapped access not refused");
  AST_PRELOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    pl_load |=> reg_q == $past(pin_i) && pl_done_q)
    else $error("preload data not loaded");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    !tick && !pl_load |=> $stable(reg_q))
    else $error("registers moved without clock edge");
  AST_CAPTURE: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    tick && !pl_load |=> reg_q == $past(sum_all))
    else $error("register did not capture OR result");
  AST_COMB_OUT: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    !macro_q[0] |=> pin_oe_n_o[0] == !$past(pt_oe[0]) && pin_o[0] == !$past(sum_rest[0]))
    else $error("combinational output wrong");
  AST_BLANK_TERM: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    cut[0] == '0 |-> !hit[0])
    else $error("fully connected term not low");
  AST_REG_OE: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i)
    macro_q[0] && $stable(macro_q[0]) |=> pin_o[0] == $past(reg_q[0]) && pin_oe_n_o[0] == $past(out_en_n_i))
    else $error("registered output path wrong");

endmodule

// >>> sop_array_pkg.sv
// constants, field layout and carrier types shared by the sum-of-products array
// assumes a single 50 MHz system clock and an APB register bus with 32-bit data
package sop_array_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 20;
  localparam int PGM_PULSE_MIN_US   = 100;
  localparam int PGM_PULSE_MAX_US   = 10000;
  localparam int PRELOAD_MIN_US     = 100;
  localparam int PGM_PULSE_MIN_CYC  = (PGM_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PGM_PULSE_MAX_CYC  = (PGM_PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int PRELOAD_MIN_CYC    = (PRELOAD_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int NUM_INPUTS         = 8;
  localparam int NUM_OUTPUTS        = 8;
  localparam int MAX_OUTPUTS        = 10;
  localparam int TERMS_PER_OUT      = 8;
  localparam int CELLS_PER_OP       = 8;
  localparam int REGULAR_BYTES      = 256;
  localparam int TEST_BYTES         = 32;

  // ---------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_PGM_ADDR  = 12'h000;
  localparam logic [11:0] OFS_PGM_DATA  = 12'h004;
  localparam logic [11:0] OFS_MACRO_CFG = 12'h008;
  localparam logic [11:0] OFS_SECURE    = 12'h00C;
  localparam logic [11:0] OFS_STATUS    = 12'h010;
  localparam int          PGM_ADDR_TEST_BIT = 8;
  localparam int          STAT_BUSY_BIT     = 0;
  localparam int          STAT_SECURE_BIT   = 1;
  localparam int          STAT_PRELOAD_BIT  = 2;
  localparam logic [9:0]  MACRO_CFG_RST     = 10'h000;
  localparam logic [8:0]  PGM_ADDR_RST      = 9'h000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic       sec;
    logic       test;
    logic [7:0] addr;
    logic [7:0] data;
  } pgm_op_t;

  typedef enum logic {PGM_IDLE, PGM_PULSE} pgm_state_t;

endpackage

// >>> product_term.sv
// one AND term of the programmable array
// assumes literals arrive as true/inverted pairs; a set cut bit removes that literal
`timescale 1ns/1ps
module product_term #(
  parameter int LITS = 32
) (
  input  wire logic [LITS-1:0] lit_i,
  input  wire logic [LITS-1:0] cut_i,
  output logic                 hit_o
);

  // ---------------------------------------------------------------
  // and of every literal still connected
  // ---------------------------------------------------------------
  // pair forces low
  // a fully connected pair always holds one low literal, so the term is low
  assign hit_o = &(lit_i | cut_i);

endmodule

// >>> board_model.sv
// board-side model: logic inputs, register clock, output enable, preload pulse, pin wiring
// assumes device pins are sampled on clk_i and device drive enables are active low
`timescale 1ns/1ps
module board_model #(
  parameter int N = 8
) (
  input  wire logic         clk_i,
  input  wire logic [N-1:0] dev_pin_i,
  input  wire logic [N-1:0] dev_oe_n_i,
  output logic [N-1:0]      in_o,
  output logic              logic_clk_o,
  output logic              out_en_n_o,
  output logic              preload_o,
  output logic [N-1:0]      pin_o
);
  logic [N-1:0] drv_q;
  logic         drv_en_q;
  logic [N-1:0] float_q;

  initial begin
    in_o = '0;
    logic_clk_o = 1'b0;
    out_en_n_o = 1'b1;
    preload_o = 1'b0;
    drv_q = '0;
    drv_en_q = 1'b0;
    float_q = {(N/2){2'b10}};
  end

  // released pins toggle so a stale level never looks valid
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  assign pin_o = (~dev_oe_n_i & dev_pin_i) | (dev_oe_n_i & (drv_en_q ? drv_q : float_q));

  task automatic set_lines(input logic [N-1:0] d, input logic oe_n);
    @(posedge clk_i);
    in_o <= d;
    out_en_n_o <= oe_n;
    repeat (3) @(posedge clk_i);
  endtask

  // register clock stands low between pulses
  task automatic clk_pulse();
    @(posedge clk_i);
    logic_clk_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    logic_clk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic preload_on(input logic [N-1:0] d);
    @(posedge clk_i);
    out_en_n_o <= 1'b1;
    drv_q <= d;
    drv_en_q <= 1'b1;
    @(posedge clk_i);
    preload_o <= 1'b1;
  endtask

  task automatic preload_off();
    @(posedge clk_i);
    preload_o <= 1'b0;
    @(posedge clk_i);
    drv_en_q <= 1'b0;
  endtask
endmodule

// >>> test_sop_array_top.sv
// self-checking bench: APB access, programming, outputs, preload and security
// assumes zero-wait APB answers and shortened pulse counts
`timescale 1ns/1ps
module test_sop_array_top;
  // busy long enough for a write to land inside it
  localparam int PGM_CYC = 10;
  localparam int PRE_CYC = 5;

  logic                    clk_i;
  logic                    sys_rst_i;
  sop_array_pkg::apb_req_t apb_q;
  logic                    pready_o;
  logic [31:0]             prdata_o;
  logic                    pslverr_o;
  logic [7:0]              in_w;
  logic                    lclk_w;
  logic                    oe_n_w;
  logic                    pre_w;
  logic [7:0]              pin_in_w;
  logic [7:0]              pin_o;
  logic [7:0]              pin_oe_n_o;
  int                      err_count;
  int                      samples_checked;
  logic [31:0]             rd;
  logic                    er;
  logic                    ce_w;
  int                      terms [4] = '{0, 1, 8, 16};
  int                      keep [4]  = '{99, 0, 2, 18};

  sop_array_top #(.PGM_CYC(PGM_CYC), .PRELOAD_CYC(PRE_CYC)) u_dut (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_w),
    .apb_i       (apb_q),
    .pready_o    (pready_o),
    .prdata_o    (prdata_o),
    .pslverr_o   (pslverr_o),
    .in_i        (in_w),
    .logic_clk_i (lclk_w),
    .out_en_n_i  (oe_n_w),
    .preload_i   (pre_w),
    .pin_i       (pin_in_w),
    .pin_o       (pin_o),
    .pin_oe_n_o  (pin_oe_n_o)
  );

  board_model #(.N(8)) u_board (
    .clk_i       (clk_i),
    .dev_pin_i   (pin_o),
    .dev_oe_n_i  (pin_oe_n_o),
    .in_o        (in_w),
    .logic_clk_o (lclk_w),
    .out_en_n_o  (oe_n_w),
    .preload_o   (pre_w),
    .pin_o       (pin_in_w)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  // no wait limit here: a hang is caught by the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk_i);
    apb_q.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    apb_q <= '0;
  endtask

  task automatic wait_idle();
    do begin
      apb(1'b0, sop_array_pkg::OFS_STATUS, 32'h0);
    end while (rd[sop_array_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic prog(input logic [8:0] a, input logic [7:0] d);
    apb(1'b1, sop_array_pkg::OFS_PGM_ADDR, 32'(a));
    apb(1'b1, sop_array_pkg::OFS_PGM_DATA, 32'(d));
    chk(32'(er), 32'h0);
    wait_idle();
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    err_count++;
    test_done();
  end

  initial begin
    sys_rst_i = 1'b1;
    apb_q = '0;
    ce_w = 1'b1;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(pin_o), 32'hFF);
    chk(32'(pin_oe_n_o), 32'hFF);
    apb(1'b0, sop_array_pkg::OFS_MACRO_CFG, 32'h0);
    chk(rd, 32'(sop_array_pkg::MACRO_CFG_RST));
    apb(1'b0, 12'h014, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("test reset done");

    apb(1'b1, sop_array_pkg::OFS_PGM_ADDR, 32'h0FF);
    apb(1'b1, sop_array_pkg::OFS_PGM_DATA, 32'h01);
    apb(1'b0, sop_array_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, sop_array_pkg::OFS_PGM_DATA, 32'h80);
    chk(32'(er), 32'h1);
    wait_idle();
    apb(1'b0, sop_array_pkg::OFS_PGM_DATA, 32'h0);
    chk(rd, 32'h01);
    // cut every literal of a term except the kept one; keep 99 matches no byte, so term 0 is cut whole
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 4; b++) begin
        prog(9'(terms[i] * 4 + b), 8'hFF & ~((keep[i] / 8 == b) ? 8'h01 << (keep[i] % 8) : 8'h00));
      end
    end
    $display("test program done");

    u_board.set_lines(8'h00, 1'b1);
    chk(32'(pin_o[0]), 32'h1);
    u_board.set_lines(8'h01, 1'b1);
    chk(32'(pin_o[0]), 32'h0);
    chk(32'(pin_oe_n_o[0]), 32'h0);
    chk(32'(pin_o[7:3]), 32'h1F);
    $display("test combinational done");

    apb(1'b1, sop_array_pkg::OFS_MACRO_CFG, 32'h6);
    apb(1'b0, sop_array_pkg::OFS_MACRO_CFG, 32'h0);
    chk(rd, 32'h6);
    u_board.preload_on(8'hA5);
    repeat (PRE_CYC + 2) @(posedge clk_i);
    apb(1'b0, sop_array_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h4);
    u_board.preload_off();
    repeat (3) @(posedge clk_i);
    chk(32'(pin_o[2:1]), 32'h2);
    apb(1'b0, sop_array_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    u_board.set_lines(8'h02, 1'b0);
    repeat (8) @(posedge clk_i);
    chk(32'(pin_o[2:1]), 32'h2);
    // a register clock pulse while frozen must be ignored
    ce_w <= 1'b0;
    u_board.clk_pulse();
    ce_w <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(32'(pin_o[2:1]), 32'h2);
    chk(32'(pin_oe_n_o[2:1]), 32'h0);
    u_board.clk_pulse();
    chk(32'(pin_o[2:1]), 32'h1);
    u_board.set_lines(8'h00, 1'b0);
    u_board.clk_pulse();
    chk(32'(pin_o[2:1]), 32'h2);
    $display("test registered done");

    apb(1'b1, sop_array_pkg::OFS_PGM_ADDR, 32'h004);
    apb(1'b0, sop_array_pkg::OFS_PGM_DATA, 32'h0);
    chk(rd, 32'hFE);
    apb(1'b1, sop_array_pkg::OFS_SECURE, 32'h1);
    wait_idle();
    chk(rd, 32'h2);
    apb(1'b0, sop_array_pkg::OFS_PGM_DATA, 32'h0);
    chk(rd, 32'h0);
    prog(9'h105, 8'h3C);
    apb(1'b0, sop_array_pkg::OFS_PGM_DATA, 32'h0);
    chk(rd, 32'h3C);
    apb(1'b1, sop_array_pkg::OFS_PGM_ADDR, 32'h120);
    apb(1'b0, sop_array_pkg::OFS_PGM_ADDR, 32'h0);
    chk(rd, 32'h120);
    apb(1'b1, sop_array_pkg::OFS_PGM_DATA, 32'h1);
    chk(32'(er), 32'h1);
    $display("test security done");
    test_done();
  end
endmodule
